// *** nand_program_copyback_cmds.sv ***
/*
  Host-side NAND controller for reset, page program and copy-back program
  in single and multi-plane forms. Assumes ready/busy arrives as an
  asynchronous pin and that page data is streamed in by the user.
*/
`timescale 1ns/1ns
`default_nettype none
module nand_program_copyback_cmds #(
  parameter int PLANES     = nand_cmd_pkg::PLANES,
  parameter int PAGE_BYTES = nand_cmd_pkg::PAGE_BYTES
) (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic                            req_valid,
  input  wire nand_cmd_pkg::op_e               req_op,
  input  wire logic                            req_last,
  input  wire logic [nand_cmd_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [nand_cmd_pkg::ADDR_W-1:0] req_src,
  output logic                                 req_ready,
  input  wire logic [7:0]                      data_byte,
  input  wire logic                            data_valid,
  output logic                                 data_ready,
  output logic                                 done,
  output logic                                 error,
  output logic                                 busy,
  output logic                                 ce_n,
  output logic                                 re_n,
  output logic                                 wp_n,
  output logic                                 cle,
  output logic                                 ale,
  output logic                                 we_n,
  output logic [7:0]                           io_out,
  output logic                                 io_oe,
  input  wire logic                            rb
);

  typedef enum logic [3:0] {
    st_power,
    st_idle,
    st_cmd1,
    st_addr1,
    st_cmd2,
    st_addr2,
    st_data,
    st_confirm,
    st_wb,
    st_rb,
    st_finish
  } state_e;

  state_e                            state;
  nand_cmd_pkg::op_e                 op;
  nand_cmd_pkg::op_e                 pend_op;
  logic                              last;
  logic                              pend;
  logic                              read_phase;
  logic                              sent;
  logic [7:0]                        cmd1_byte;
  logic [nand_cmd_pkg::ADDR_W-1:0]   addr;
  logic [nand_cmd_pkg::ADDR_W-1:0]   src;
  logic [1:0]                        acnt;
  logic [9:0]                        bcnt;
  logic [2:0]                        planes;
  logic [15:0]                       timer;
  logic                              rb_meta;
  logic                              rb_sync;
  logic                              eng_start;
  nand_cmd_pkg::kind_e               eng_kind;
  logic [7:0]                        eng_byte;
  logic                              eng_done;

  //////////////////////////////////////////////////////////////////////////
  // Request checks and byte selection.
  wire accept  = req_valid && req_ready;
  wire is_cb   = (op == nand_cmd_pkg::op_copyback);
  wire same_hi = (req_src[nand_cmd_pkg::PLANE_HI_A] ==
                  req_addr[nand_cmd_pkg::PLANE_HI_A]) &&
                 (req_src[nand_cmd_pkg::PLANE_HI_B] ==
                  req_addr[nand_cmd_pkg::PLANE_HI_B]);
  wire same_lo = (req_src[nand_cmd_pkg::PLANE_LO_A] ==
                  req_addr[nand_cmd_pkg::PLANE_LO_A]) &&
                 (req_src[nand_cmd_pkg::PLANE_LO_B] ==
                  req_addr[nand_cmd_pkg::PLANE_LO_B]);
  wire is_write = (req_op != nand_cmd_pkg::op_reset);
  wire cb_bad   = (req_op == nand_cmd_pkg::op_copyback) &&
                  !(same_hi && same_lo);
  wire mix_bad  = is_write && pend && (pend_op != req_op);
  wire full_bad = is_write && !req_last &&
                  (planes == 3'(PLANES - 1));
  wire reject   = cb_bad || mix_bad || full_bad;
  wire [7:0] first_cmd =
    (req_op == nand_cmd_pkg::op_reset)   ? nand_cmd_pkg::CMD_RESET :
    (req_op == nand_cmd_pkg::op_program) ? nand_cmd_pkg::CMD_PROG :
    pend ? nand_cmd_pkg::CMD_CB_READ_DM : nand_cmd_pkg::CMD_CB_READ;
  wire [7:0] end_cmd = last ? nand_cmd_pkg::CMD_CONFIRM
                            : nand_cmd_pkg::CMD_DUMMY_END;
  wire issuing = (state == st_cmd1) || (state == st_addr1) ||
                 (state == st_cmd2) || (state == st_addr2) ||
                 (state == st_data) || (state == st_confirm);
  wire can_go  = (state != st_data) || data_valid;
  wire [7:0] cur_byte =
    (state == st_cmd1)  ? cmd1_byte :
    (state == st_addr1) ? nand_cmd_pkg::addr_byte(is_cb ? src : addr, acnt) :
    (state == st_cmd2)  ? nand_cmd_pkg::CMD_CB_PROG :
    (state == st_addr2) ? nand_cmd_pkg::addr_byte(addr, acnt) :
    (state == st_data)  ? data_byte : end_cmd;
  wire nand_cmd_pkg::kind_e cur_kind =
    ((state == st_addr1) || (state == st_addr2)) ? nand_cmd_pkg::kind_addr :
    (state == st_data) ? nand_cmd_pkg::kind_data : nand_cmd_pkg::kind_cmd;
  wire addr_end  = (acnt == 2'(nand_cmd_pkg::ADDR_CYCLES - 1));
  wire page_end  = (bcnt == 10'(PAGE_BYTES - 1));
  wire pwr_end   = (timer == 16'(nand_cmd_pkg::POWERUP_CYC - 1));
  wire wb_end    = (timer == 16'(nand_cmd_pkg::TWB_CYC - 1));
  wire rst_late  = (op == nand_cmd_pkg::op_reset) &&
                   (timer >= 16'(nand_cmd_pkg::RST_BUSY_CYC));

  //////////////////////////////////////////////////////////////////////////
  // Ready/busy pin synchroniser.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rb_meta <= 1'b0;
      rb_sync <= 1'b0;
    end else begin
      rb_meta <= rb;
      rb_sync <= rb_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= st_power;
      op         <= nand_cmd_pkg::op_reset;
      pend_op    <= nand_cmd_pkg::op_reset;
      last       <= 1'b1;
      pend       <= 1'b0;
      read_phase <= 1'b0;
      sent       <= 1'b0;
      cmd1_byte  <= 8'h00;
      addr       <= '0;
      src        <= '0;
      acnt       <= 2'h0;
      bcnt       <= 10'h000;
      planes     <= 3'h0;
      timer      <= 16'h0000;
      req_ready  <= 1'b0;
      data_ready <= 1'b0;
      done       <= 1'b0;
      error      <= 1'b0;
      busy       <= 1'b1;
      ce_n       <= 1'b1;
      re_n       <= 1'b1;
      wp_n       <= 1'b1;
      eng_start  <= 1'b0;
      eng_kind   <= nand_cmd_pkg::kind_cmd;
      eng_byte   <= 8'h00;
    end else begin
      eng_start  <= 1'b0;
      data_ready <= 1'b0;
      done       <= 1'b0;
      error      <= 1'b0;
      timer      <= timer + 16'h0001;
      if (issuing && !sent && can_go) begin
        eng_start  <= 1'b1;
        eng_kind   <= cur_kind;
        eng_byte   <= cur_byte;
        sent       <= 1'b1;
        data_ready <= (state == st_data);
      end else if (issuing && eng_done) begin
        sent <= 1'b0;
        acnt <= acnt + 2'h1;
      end
      unique case (state)
        st_power: if (pwr_end) begin
          state     <= st_idle;
          req_ready <= 1'b1;
          busy      <= 1'b0;
        end
        st_idle: if (accept) begin
          if (reject) begin
            error <= 1'b1;
          end else begin
            state     <= st_cmd1;
            req_ready <= 1'b0;
            busy      <= 1'b1;
            ce_n      <= 1'b0;
            op        <= req_op;
            last      <= req_last || !is_write;
            addr      <= req_addr;
            src       <= req_src;
            cmd1_byte <= first_cmd;
          end
        end
        st_cmd1: if (sent && eng_done) begin
          acnt  <= 2'h0;
          timer <= 16'h0000;
          state <= (op == nand_cmd_pkg::op_reset) ? st_wb : st_addr1;
        end
        st_addr1: if (sent && eng_done && addr_end) begin
          bcnt       <= 10'h000;
          timer      <= 16'h0000;
          read_phase <= is_cb;
          state      <= is_cb ? st_wb : st_data;
        end
        st_cmd2: if (sent && eng_done) begin
          acnt  <= 2'h0;
          state <= st_addr2;
        end
        st_addr2: if (sent && eng_done && addr_end) begin
          state <= st_confirm;
        end
        st_data: if (sent && eng_done) begin
          bcnt <= bcnt + 10'h001;
          if (page_end) begin
            state <= st_confirm;
          end
        end
        st_confirm: if (sent && eng_done) begin
          timer <= 16'h0000;
          state <= st_wb;
        end
        st_wb: if (wb_end) begin
          state <= st_rb;
        end
        st_rb: begin
          if (rst_late) begin
            error <= 1'b1;
            state <= st_finish;
          end else if (rb_sync) begin
            read_phase <= 1'b0;
            state      <= read_phase ? st_cmd2 : st_finish;
          end
        end
        st_finish: begin
          state     <= st_idle;
          done      <= 1'b1;
          busy      <= 1'b0;
          ce_n      <= 1'b1;
          req_ready <= 1'b1;
          pend_op   <= op;
          pend      <= !last;
          planes    <= last ? 3'h0 : planes + 3'h1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin cycle engine.
  nand_write_cycle u_cycle (
    .clk    (clk),
    .nrst   (nrst),
    .start  (eng_start),
    .kind   (eng_kind),
    .data   (eng_byte),
    .cle    (cle),
    .ale    (ale),
    .we_n   (we_n),
    .io_out (io_out),
    .io_oe  (io_oe),
    .done   (eng_done)
  );

endmodule
`default_nettype wire

// *** nand_cmd_pkg.sv ***
/*
  Constants, command codes and enumerations for the NAND program and
  copy-back command controller. Assumes a 100 MHz system clock and a
  byte-wide NAND device behind CLE/ALE/WE/CE pins.
*/
// Function
// - Copy-back source and target keep address bits 24 and 25 equal.
// - Copy-back source and target keep address bits 14 and 15 equal.
// - Wait at least 1 us after power-up before any command.
// - Single plane: program 80h then 10h; copy-back 00h, 8Ah, 10h.
// - Planes two to four use 80h/11h and 03h, 8Ah, 11h or 10h.
// - Commands, addresses and data share the eight-bit port.
package nand_cmd_pkg;

  localparam int CLK_NS          = 10;
  localparam int POWERUP_NS      = 1000;
  localparam int POWERUP_CYC     = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_BUSY_NS     = 5000;
  localparam int RST_BUSY_CYC    = RST_BUSY_NS / CLK_NS;
  localparam int TWB_NS          = 100;
  localparam int TWB_CYC         = (TWB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_SETUP_CYC    = 2;
  localparam int WE_LOW_CYC      = 3;
  localparam int WE_HOLD_CYC     = 2;

  localparam int PAGE_MAIN       = 512;
  localparam int PAGE_SPARE      = 16;
  localparam int PAGE_BYTES      = PAGE_MAIN + PAGE_SPARE;
  localparam int BLOCK_MAIN      = 16384;
  localparam int BLOCK_SPARE     = 512;
  localparam int PLANES          = 4;
  localparam int ADDR_W          = 26;
  localparam int ADDR_CYCLES     = 4;
  localparam int IO_W            = 8;

  localparam int PLANE_HI_A      = 24;
  localparam int PLANE_HI_B      = 25;
  localparam int PLANE_LO_A      = 14;
  localparam int PLANE_LO_B      = 15;

  localparam logic [7:0] CMD_PROG       = 8'h80;
  localparam logic [7:0] CMD_CONFIRM    = 8'h10;
  localparam logic [7:0] CMD_DUMMY_END  = 8'h11;
  localparam logic [7:0] CMD_CB_READ    = 8'h00;
  localparam logic [7:0] CMD_CB_READ_DM = 8'h03;
  localparam logic [7:0] CMD_CB_PROG    = 8'h8A;
  localparam logic [7:0] CMD_RESET      = 8'hFF;

  typedef enum logic [1:0] {
    op_reset,
    op_program,
    op_copyback
  } op_e;

  typedef enum logic [1:0] {
    kind_cmd,
    kind_addr,
    kind_data
  } kind_e;

  // Byte of a four-cycle address; bit 8 is left to the 00h read pointer.
  function automatic logic [7:0] addr_byte(input logic [ADDR_W-1:0] a,
                                           input logic [1:0]        i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      2'd0: b = a[7:0];
      2'd1: b = a[16:9];
      2'd2: b = a[24:17];
      2'd3: b = {7'h00, a[25]};
    endcase
    return b;
  endfunction

endpackage

// *** nand_write_cycle.sv ***
/*
  One latched write cycle on the shared NAND byte port: command, address
  or data. Assumes the caller waits for done before the next start.
*/
`timescale 1ns/1ns
`default_nettype none
module nand_write_cycle (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                start,
  input  wire nand_cmd_pkg::kind_e kind,
  input  wire logic [7:0]          data,
  output logic                     cle,
  output logic                     ale,
  output logic                     we_n,
  output logic [7:0]               io_out,
  output logic                     io_oe,
  output logic                     done
);

  typedef enum logic [1:0] {
    ph_idle,
    ph_setup,
    ph_low,
    ph_hold
  } phase_e;

  phase_e     phase;
  logic [2:0] cnt;

  wire last_setup = (cnt == 3'(nand_cmd_pkg::WE_SETUP_CYC - 1));
  wire last_low   = (cnt == 3'(nand_cmd_pkg::WE_LOW_CYC - 1));
  wire last_hold  = (cnt == 3'(nand_cmd_pkg::WE_HOLD_CYC - 1));

  //////////////////////////////////////////////////////////////////////////
  // Strobes select what the byte on the port means.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase  <= ph_idle;
      cnt    <= 3'h0;
      cle    <= 1'b0;
      ale    <= 1'b0;
      we_n   <= 1'b1;
      io_out <= 8'h00;
      io_oe  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      cnt  <= cnt + 3'h1;
      unique case (phase)
        ph_idle: begin
          cnt <= 3'h0;
          if (start) begin
            phase  <= ph_setup;
            cle    <= (kind == nand_cmd_pkg::kind_cmd);
            ale    <= (kind == nand_cmd_pkg::kind_addr);
            io_out <= data;
            io_oe  <= 1'b1;
          end
        end
        ph_setup: if (last_setup) begin
          phase <= ph_low;
          cnt   <= 3'h0;
          we_n  <= 1'b0;
        end
        ph_low: if (last_low) begin
          phase <= ph_hold;
          cnt   <= 3'h0;
          we_n  <= 1'b1;
        end
        ph_hold: if (last_hold) begin
          phase <= ph_idle;
          cle   <= 1'b0;
          ale   <= 1'b0;
          io_oe <= 1'b0;
          done  <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** nand_program_copyback_cmds_asserts.sv ***
/*
  Concurrent checks on the NAND command controller's ports.
  Assumes it is bound into nand_program_copyback_cmds.
*/
`timescale 1ns/1ns
`default_nettype none
module nand_program_copyback_cmds_asserts (
  input wire logic                            clk,
  input wire logic                            nrst,
  input wire logic                            req_valid,
  input wire nand_cmd_pkg::op_e               req_op,
  input wire logic [nand_cmd_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nand_cmd_pkg::ADDR_W-1:0] req_src,
  input wire logic                            req_ready,
  input wire logic                            done,
  input wire logic                            error,
  input wire logic                            ce_n,
  input wire logic                            cle,
  input wire logic                            ale,
  input wire logic                            we_n,
  input wire logic [7:0]                      io_out,
  input wire logic                            io_oe
);
  logic [7:0] up_cnt;
  logic       take;
  logic       cb_take;

  assign take    = req_valid && req_ready;
  assign cb_take = take && req_op == nand_cmd_pkg::op_copyback;

  // Counts cycles since reset release, saturating.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      up_cnt <= 8'h00;
    else if (up_cnt != 8'hFF)
      up_cnt <= up_cnt + 8'h01;
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  powerup_quiet_a: assert property (
    up_cnt < 8'h64 |-> we_n && !req_ready)
    else $error("pin activity before power-up wait ended");
  latch_excl_a: assert property (
    !(cle && ale))
    else $error("command and address latch both high");
  strobe_qual_a: assert property (
    !we_n |-> !ce_n && io_oe)
    else $error("write strobe without chip enable or drive");
  we_low_len_a: assert property (
    $fell(we_n) |-> !we_n [*3] ##1 we_n)
    else $error("write strobe low time wrong");
  io_steady_a: assert property (
    !we_n |-> $stable(io_out) && $stable(cle) && $stable(ale))
    else $error("byte lanes moved while strobe low");
  plane_hi_rej_a: assert property (
    cb_take && req_addr[25:24] != req_src[25:24] |-> ##[1:2] error)
    else $error("high plane bit mismatch not refused");
  plane_lo_rej_a: assert property (
    cb_take && req_addr[15:14] != req_src[15:14] |-> ##[1:2] error)
    else $error("low plane bit mismatch not refused");
  reset_code_a: assert property (
    take && req_op == nand_cmd_pkg::op_reset
      |-> ##[1:40] cle && !we_n && io_out == 8'hFF)
    else $error("reset code not issued");
  prog_code_a: assert property (
    take && req_op == nand_cmd_pkg::op_program
      |-> ##[1:40] error || (cle && !we_n && io_out == 8'h80))
    else $error("program code not issued");
  confirm_gap_a: assert property (
    $rose(we_n) && cle && (io_out == 8'h10 || io_out == 8'h11)
      |-> we_n [*8])
    else $error("write issued right after confirm");
  done_pulse_a: assert property (
    done |=> !done)
    else $error("done wider than one cycle");
endmodule
bind nand_program_copyback_cmds nand_program_copyback_cmds_asserts u_chk (
  .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
  .req_addr(req_addr), .req_src(req_src), .req_ready(req_ready),
  .done(done), .error(error), .ce_n(ce_n), .cle(cle), .ale(ale),
  .we_n(we_n), .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

// *** nand_dev_model.sv ***
/*
  Behavioural NAND device: logs latched bytes and drives ready/busy.
  Assumes registered host pins; the bench sets the busy time.
*/
`timescale 1ns/1ns
`default_nettype none
module nand_dev_model (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic [7:0]  io,
  input  wire logic [15:0] busy_cyc,
  output logic             rb
);
  logic [7:0] cmd_log[$];
  logic [7:0] addr_log[$];
  int         data_log[$];
  logic       we_q = 1'b1;
  logic [7:0] last_cmd = 8'h00;
  int         n_addr = 0;
  int         n_data = 0;
  int         open_cnt = 0;
  int         wait_cnt = 0;

  // Bytes are taken on the rising strobe edge while selected.
  always @(posedge clk) begin
    we_q <= we_n;
    if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
    if (we_n && !we_q && !ce_n) begin
      if (cle) begin
        cmd_log.push_back(io);
        last_cmd <= io;
        n_addr <= 0;
        n_data <= 0;
        if (io == 8'hFF) begin
          wait_cnt <= busy_cyc;
          open_cnt <= 0;
        end
        if (io == 8'h10 || (io == 8'h11 && open_cnt < 3)) begin
          wait_cnt <= busy_cyc;
          data_log.push_back(n_data);
          open_cnt <= (io == 8'h11) ? open_cnt + 1 : 0;
        end
      end else if (ale) begin
        addr_log.push_back(io);
        n_addr <= n_addr + 1;
        if (n_addr == 3 && (last_cmd == 8'h00 || last_cmd == 8'h03))
          wait_cnt <= busy_cyc;
      end else
        n_data <= n_data + 1;
    end
  end
  assign rb = (wait_cnt == 0);
endmodule
`default_nettype wire

// *** tb_nand_program_copyback_cmds.sv ***
/*
  Self-checking bench for the NAND command controller.
  Assumes nand_dev_model on the pins and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_nand_program_copyback_cmds;
  localparam nand_cmd_pkg::op_e OP_R = nand_cmd_pkg::op_reset;
  localparam nand_cmd_pkg::op_e OP_P = nand_cmd_pkg::op_program;
  localparam nand_cmd_pkg::op_e OP_C = nand_cmd_pkg::op_copyback;
  logic              clk, nrst, req_valid, req_last, data_valid, rb;
  nand_cmd_pkg::op_e req_op;
  logic [25:0]       req_addr, req_src;
  logic [7:0]        data_byte, io_out;
  logic              req_ready, data_ready, done, error, busy, ce_n;
  logic              re_n, wp_n, cle, ale, we_n, io_oe;
  logic [15:0]       busy_cyc;
  int                error_cnt = 0;
  int                total_checks = 0;

  nand_program_copyback_cmds dut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
    .req_last(req_last), .req_addr(req_addr), .req_src(req_src),
    .req_ready(req_ready), .data_byte(data_byte), .data_valid(data_valid),
    .data_ready(data_ready), .done(done), .error(error), .busy(busy),
    .ce_n(ce_n), .re_n(re_n), .wp_n(wp_n), .cle(cle), .ale(ale),
    .we_n(we_n), .io_out(io_out), .io_oe(io_oe), .rb(rb));
  nand_dev_model dev (
    .clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .io(io_out), .busy_cyc(busy_cyc), .rb(rb));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic step(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 20000) begin
      chk("wait limit", 0, n);
      tally_and_finish();
    end
  endtask

  task automatic do_req(input nand_cmd_pkg::op_e op, input logic last,
                        input logic [25:0] a, input logic [25:0] s,
                        input logic exp_err);
    int n;
    int i;
    n = 0;
    while (req_ready !== 1'b1)
      step(n);
    req_valid = 1'b1;
    req_op = op;
    req_last = last;
    req_addr = a;
    req_src = s;
    step(n);
    req_valid = 1'b0;
    chk("busy on accept", op == OP_R || !exp_err, busy);
    chk("chip enable on accept", !(op == OP_R || !exp_err), ce_n);
    if (op == OP_P && !exp_err) begin
      data_valid = 1'b1;
      for (i = 0; i < 528; i++) begin
        data_byte = i[7:0];
        n = 0;
        do step(n); while (data_ready !== 1'b1);
      end
      data_valid = 1'b0;
    end
    n = 0;
    while (done !== 1'b1 && error !== 1'b1)
      step(n);
    if (exp_err && error !== 1'b1)
      step(n);
    chk("error flag", exp_err, error);
  endtask

  task automatic chk_log(input string what, input logic [7:0] exp[$]);
    chk(what, exp.size(), dev.cmd_log.size());
    foreach (exp[i])
      if (i < dev.cmd_log.size())
        chk(what, exp[i], dev.cmd_log[i]);
    dev.cmd_log.delete();
    dev.addr_log.delete();
    dev.data_log.delete();
  endtask

  task automatic chk_addr(input logic [25:0] a, input int b);
    chk("addr byte 0", a[7:0], dev.addr_log[b]);
    chk("addr byte 1", a[16:9], dev.addr_log[b + 1]);
    chk("addr byte 2", a[24:17], dev.addr_log[b + 2]);
    chk("addr byte 3", {7'h00, a[25]}, dev.addr_log[b + 3]);
  endtask

  task automatic chk_pages(input int n);
    chk("page count", n, dev.data_log.size());
    foreach (dev.data_log[i])
      chk("page bytes", 528, dev.data_log[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup;
    int n;
    n = 0;
    while (req_ready !== 1'b1)
      step(n);
    chk("power-up wait", 1, n >= 100);
    chk("busy after power-up", 0, busy);
    chk("read strobe idle", 1, re_n);
    chk("write protect off", 1, wp_n);
    chk("power-up writes", 0, dev.cmd_log.size());
    $display("test power-up finished");
  endtask

  task automatic t_reset;
    busy_cyc = 16'h0028;
    do_req(OP_R, 1'b1, 26'h0000000, 26'h0000000, 1'b0);
    busy_cyc = 16'h0258;
    do_req(OP_R, 1'b1, 26'h0000000, 26'h0000000, 1'b1);
    chk_log("reset cmds", '{8'hFF, 8'hFF});
    busy_cyc = 16'h0020;
    $display("test reset finished");
  endtask

  task automatic t_program;
    do_req(OP_P, 1'b1, 26'h1234567, 26'h0000000, 1'b0);
    chk_addr(26'h1234567, 0);
    chk_pages(1);
    chk_log("program cmds", '{8'h80, 8'h10});
    $display("test program finished");
  endtask

  task automatic t_multi;
    int p;
    for (p = 0; p < 3; p++)
      do_req(OP_P, 1'b0, 26'(p) << 14, 26'h0000000, 1'b0);
    do_req(OP_P, 1'b0, 26'h000C000, 26'h0000000, 1'b1);
    do_req(OP_C, 1'b1, 26'h000C000, 26'h000C000, 1'b1);
    do_req(OP_P, 1'b1, 26'h000C000, 26'h0000000, 1'b0);
    chk_pages(4);
    chk_log("multi cmds", '{8'h80, 8'h11, 8'h80, 8'h11, 8'h80, 8'h11,
                            8'h80, 8'h10});
    $display("test multi-plane program finished");
  endtask

  task automatic t_copyback;
    do_req(OP_C, 1'b1, 26'h2C0C321, 26'h2D1C321, 1'b0);
    do_req(OP_C, 1'b0, 26'h2C0C321, 26'h2D1C321, 1'b0);
    do_req(OP_C, 1'b1, 26'h2C08321, 26'h2D18321, 1'b0);
    chk_addr(26'h2D1C321, 0);
    chk_addr(26'h2C0C321, 4);
    chk_addr(26'h2D18321, 16);
    chk_log("copy-back cmds", '{8'h00, 8'h8A, 8'h10, 8'h00, 8'h8A, 8'h11,
                                8'h03, 8'h8A, 8'h10});
    $display("test copy-back finished");
  endtask

  task automatic t_cb_reject;
    int bits[4] = '{24, 25, 14, 15};
    foreach (bits[i])
      do_req(OP_C, 1'b1, 26'h1000000, 26'h1000000 ^ (26'h1 << bits[i]),
             1'b1);
    chk("refused writes", 0, dev.cmd_log.size());
    $display("test copy-back refusal finished");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_op = OP_R;
    req_last = 1'b1;
    req_addr = 26'h0000000;
    req_src = 26'h0000000;
    data_byte = 8'h00;
    data_valid = 1'b0;
    busy_cyc = 16'h0020;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_powerup();
    t_reset();
    t_program();
    t_multi();
    t_copyback();
    t_cb_reject();
    tally_and_finish();
  end
endmodule
`default_nettype wire
